// File: include/pins_regs.svh
// offsets, fields, resets and timing counts of the pin block
//==============================================================
// Overview of operation
// - program-store strobe pulses low, high unless a code fetch runs
// - address latch strobe is two oscillator cycles wide (1.5 rounded up), every four cycles
// - address latch strobe is forced high while reset is held
// - strobe-suppress bit set to 1 stops the latch strobe, holding it high
// - memory accesses pulse the latch strobe whatever the suppress bit says
// - low-byte port is 8 bits, bidirectional, open-drain as general I/O
// - while the latch strobe is high the low address byte sits on the port
// - after the latch strobe falls the low port becomes the data bus
// - as a memory bus the low port drives high levels actively
// - reset leaves low-port pins at high impedance
// - reset sets second-port latch bits to 1, pins held by weak pullup
// - a second-port pin latched at 1 also reads as an input
// - writing 0 to a second-port bit turns on a strong pulldown until 1 or reset
// - writing 1 over 0 gives a brief strong pull-up, then weak pullup
// - second-port bits 0 and 1 carry timer 2 I/O and its trigger
// - second-port bits 2 and 3 carry serial port 1 receive and transmit
// - bit 4 is rising-edge interrupt 2, bit 5 falling-edge interrupt 3
// - bit 6 is rising-edge interrupt 4, bit 7 falling-edge interrupt 5
// - upper address port gives the high address byte during accesses
`ifndef PINS_REGS_SVH
`define PINS_REGS_SVH

//==============================================================
// register byte offsets
`define OFS_POWER_MGMT 8'h00
`define OFS_LOW_LATCH 8'h04
`define OFS_LOW_PINS 8'h08
`define OFS_SECOND_LATCH 8'h0c
`define OFS_SECOND_PINS 8'h10
`define OFS_EDGE_FLAGS 8'h14
`define OFS_BUS_STATUS 8'h18

//==============================================================
// fields and reset values
`define STROBE_SUPPRESS_POS 2
`define LATCH_RESET 8'hff
`define EDGE_RISE_MASK 4'h5

//==============================================================
// timing in oscillator cycles (aclk is the oscillator)
`define ALE_WIDTH_TENTHS 15
`define ALE_HIGH_CYC ((`ALE_WIDTH_TENTHS + 9) / 10)
`define ALE_PERIOD_CYC 4

`endif

// File: include/pins_pkg.sv
// types shared by the pin block modules
package pins_pkg;

  // kind of external memory cycle requested by the core side
  typedef enum logic [1:0] {
    ACC_FETCH,
    ACC_READ,
    ACC_WRITE
  } acc_kind_t;

  typedef logic [1:0] phase_t;

endpackage

// File: core/edge_detect.sv
// edge detector for the four external interrupt pins
`timescale 1ns/1ps
`include "pins_regs.svh"
module edge_detect
  import pins_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] pins,
  output logic [3:0] pulse
);

  logic [3:0] prev_r;
  logic valid_r;
  localparam logic [3:0] RISE = `EDGE_RISE_MASK;

  // one sample per clock; the first after reset is not compared, so no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 4'hf;
      valid_r <= 1'b0;
    end else begin
      prev_r <= pins;
      valid_r <= 1'b1;
    end
  end

  // rising on bits 0 and 2, falling on bits 1 and 3
  always_comb begin
    pulse = {4{valid_r}} & ((RISE & pins & ~prev_r) | (~RISE & ~pins & prev_r));
  end

  edge_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (valid_r && prev_r[0] == 1'b0 && pins[0]) |-> pulse[0])
    else $error("rising edge on interrupt 2 missed");

  edge_fall_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pulse[3] |-> (!pins[3] && $past(pins[3])))
    else $error("falling pulse on interrupt 5 without a falling edge");

endmodule // edge_detect

// File: core/strobe_gen.sv
// machine-cycle phase counter and address latch strobe
`timescale 1ns/1ps
`include "pins_regs.svh"
module strobe_gen
  import pins_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic suppress,
  input wire logic acc_next,
  output phase_t phase,
  output logic ale
);

  localparam phase_t LAST = phase_t'(`ALE_PERIOD_CYC - 1);
  localparam phase_t HIGH_END = phase_t'(`ALE_HIGH_CYC - 1);

  // free-running four-state phase, one machine cycle per wrap
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= LAST;
    end else begin
      phase <= (phase == LAST) ? '0 : phase + 2'd1;
    end
  end

  // low half kept high only while suppressed and idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ale <= 1'b1;
    end else if (phase == LAST) begin
      ale <= 1'b1;
    end else if (phase < HIGH_END) begin
      ale <= ale;
    end else begin
      ale <= ale && suppress && !acc_next;
    end
  end

  ale_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(ale) && phase == 2'd0 && !suppress) ##1 !suppress |-> ale ##1 !ale [*2])
    else $error("latch strobe not two cycles high in a four cycle period");

endmodule // strobe_gen

// File: core/port_and_external_bus_pins.sv
// external bus strobes, open-drain low port and quasi-bidirectional second port
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "pins_regs.svh"
module port_and_external_bus_pins
  import pins_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core-side external memory request
  input wire logic mem_req,
  input wire acc_kind_t mem_kind,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_done,
  // strobes and upper address port
  output logic program_store_strobe_n,
  output logic addr_latch_strobe,
  output logic [7:0] addr_high_out,
  output logic [7:0] addr_high_oe_n,
  // multiplexed low address/data port
  input wire logic [7:0] mux_addr_data_low_in,
  output logic [7:0] mux_addr_data_low_out,
  output logic [7:0] mux_addr_data_low_oe_n,
  // second port pins
  input wire logic [7:0] second_port_in,
  output logic [7:0] second_port_out,
  output logic [7:0] second_port_oe_n,
  output logic [7:0] second_port_weak_pullup,
  // alternate functions of the second port
  output logic timer2_io_pin,
  input wire logic timer2_drive,
  output logic timer2_trigger_pin,
  output logic serial1_receive,
  input wire logic serial1_transmit,
  output logic ext_irq_two_rise,
  output logic ext_irq_three_fall,
  output logic ext_irq_four_rise,
  output logic ext_irq_five_fall
);

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  //==============================================================
  // declarations
  phase_t phase;
  logic acc_r;
  logic acc_nxt;
  acc_kind_t kind_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] power_management_reg_r;
  logic [7:0] low_latch_r;
  logic [7:0] second_latch_r;
  logic [7:0] second_eff;
  logic [7:0] eff_prev_r;
  logic [7:0] kick;
  logic [3:0] edge_pulse;
  logic [3:0] edge_flags_r;
  logic strobe_suppress_bit;
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wlane_r;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] rd_byte;
  logic rd_hit;

  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a == `OFS_POWER_MGMT) || (a == `OFS_LOW_LATCH) || (a == `OFS_LOW_PINS) ||
      (a == `OFS_SECOND_LATCH) || (a == `OFS_SECOND_PINS) || (a == `OFS_EDGE_FLAGS) ||
      (a == `OFS_BUS_STATUS);
  endfunction

  function automatic logic wr_to(input logic [7:0] a);
    wr_to = wr_fire && wlane_r && (awaddr_r == a);
  endfunction

  assign strobe_suppress_bit = power_management_reg_r[`STROBE_SUPPRESS_POS];

  //==============================================================
  // AXI4-Lite write channel: address and data held until both are in
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wbyte_r <= s_axi_wdata[7:0];
      wlane_r <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end
  end

  // response one cycle after both halves are held; unmapped offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known_ofs(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //==============================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      `OFS_POWER_MGMT: rd_byte = power_management_reg_r;
      `OFS_LOW_LATCH: rd_byte = low_latch_r;
      `OFS_LOW_PINS: rd_byte = mux_addr_data_low_in;
      `OFS_SECOND_LATCH: rd_byte = second_latch_r;
      `OFS_SECOND_PINS: rd_byte = second_port_in;
      `OFS_EDGE_FLAGS: rd_byte = {4'h0, edge_flags_r};
      `OFS_BUS_STATUS: rd_byte = {7'h00, acc_r};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //==============================================================
  // software registers; only the suppress bit of power management is writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_management_reg_r <= 8'h00;
    end else if (wr_to(`OFS_POWER_MGMT)) begin
      power_management_reg_r <= wbyte_r & (8'h01 << `STROBE_SUPPRESS_POS);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_latch_r <= `LATCH_RESET;
    end else if (wr_to(`OFS_LOW_LATCH)) begin
      low_latch_r <= wbyte_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      second_latch_r <= `LATCH_RESET;
    end else if (wr_to(`OFS_SECOND_LATCH)) begin
      second_latch_r <= wbyte_r;
    end
  end

  // sticky edge flags, write one to clear; a new edge wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_flags_r <= 4'h0;
    end else begin
      edge_flags_r <= (edge_flags_r & ~(wr_to(`OFS_EDGE_FLAGS) ? wbyte_r[3:0] : 4'h0))
        | edge_pulse;
    end
  end

  //==============================================================
  // external memory cycle: one machine cycle, taken at the boundary
  // back-to-back requests are refused, so a held request runs at most every other machine cycle
  assign acc_nxt = (phase == 2'd3) ? (mem_req && !acc_r) : acc_r;

  strobe_gen u_strobe (
    .aclk(aclk),
    .aresetn(aresetn),
    .suppress(strobe_suppress_bit),
    .acc_next(acc_nxt),
    .phase(phase),
    .ale(addr_latch_strobe)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= 1'b0;
      kind_r <= ACC_FETCH;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
    end else begin
      acc_r <= acc_nxt;
      if (phase == 2'd3 && mem_req && !acc_r) begin
        kind_r <= mem_kind;
        addr_r <= mem_addr;
        wdata_r <= mem_wdata;
      end
    end
  end

  // read data taken from the pins at the end of the data half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_rdata <= 8'h00;
      mem_done <= 1'b0;
    end else begin
      mem_done <= acc_r && phase == 2'd3;
      if (acc_r && phase == 2'd3 && kind_r != ACC_WRITE) begin
        mem_rdata <= mux_addr_data_low_in;
      end
    end
  end

  //==============================================================
  // pin drive for the bus side
  always_comb begin
    program_store_strobe_n = !(acc_r && kind_r == ACC_FETCH && phase[1]);
    addr_high_out = acc_r ? addr_r[15:8] : 8'hff;
    addr_high_oe_n = {8{!acc_r}};
  end

  // address half drives all bits, data half only on writes; idle is open-drain
  always_comb begin
    if (acc_r && !phase[1]) begin
      mux_addr_data_low_out = addr_r[7:0];
      mux_addr_data_low_oe_n = 8'h00;
    end else if (acc_r) begin
      mux_addr_data_low_out = wdata_r;
      mux_addr_data_low_oe_n = {8{kind_r != ACC_WRITE}};
    end else begin
      mux_addr_data_low_out = 8'h00;
      mux_addr_data_low_oe_n = low_latch_r;
    end
  end

  //==============================================================
  // second port: quasi-bidirectional with alternate outputs merged into the latch
  always_comb begin
    second_eff = second_latch_r & {4'hf, serial1_transmit, 2'b11, timer2_drive};
    kick = second_eff & ~eff_prev_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eff_prev_r <= `LATCH_RESET;
    end else begin
      eff_prev_r <= second_eff;
    end
  end

  // strong low for 0, one strong-high cycle after a rise, else weak pullup
  always_comb begin
    second_port_out = second_eff;
    second_port_oe_n = second_eff & ~kick;
    second_port_weak_pullup = second_eff;
  end

  // alternate inputs read the pins directly
  always_comb begin
    timer2_io_pin = second_port_in[0];
    timer2_trigger_pin = second_port_in[1];
    serial1_receive = second_port_in[2];
  end

  edge_detect u_edges (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(second_port_in[7:4]),
    .pulse(edge_pulse)
  );

  assign ext_irq_two_rise = edge_pulse[0];
  assign ext_irq_three_fall = edge_pulse[1];
  assign ext_irq_four_rise = edge_pulse[2];
  assign ext_irq_five_fall = edge_pulse[3];

  //==============================================================
  // checks
  program_store_strobe_n_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!acc_r || kind_r != ACC_FETCH) |-> program_store_strobe_n)
    else $error("program strobe low outside a fetch");

  program_store_strobe_n_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (acc_r && kind_r == ACC_FETCH && phase == 2'd1) |=> !program_store_strobe_n [*2])
    else $error("program strobe not low for the data half of a fetch");

  ale_reset_a: assert property (@(posedge aclk)
    !aresetn |=> addr_latch_strobe)
    else $error("latch strobe not high after reset");

  ale_suppress_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (phase == 2'd3 && strobe_suppress_bit && !acc_nxt) ##2 strobe_suppress_bit
      |=> addr_latch_strobe)
    else $error("latch strobe pulsed while suppressed");

  ale_access_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (acc_r && phase == 2'd0) |-> addr_latch_strobe)
    else $error("latch strobe missing during an access");

  addr_present_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (acc_r && addr_latch_strobe) |->
      (mux_addr_data_low_out == addr_r[7:0] && mux_addr_data_low_oe_n == 8'h00))
    else $error("low address byte not driven while latch strobe high");

  low_reset_a: assert property (@(posedge aclk)
    !aresetn |=> (mux_addr_data_low_oe_n == 8'hff))
    else $error("low port not released after reset");

  second_reset_a: assert property (@(posedge aclk)
    !aresetn |=> (second_latch_r == 8'hff && second_port_weak_pullup == 8'hff))
    else $error("second port latch not all ones after reset");

  pulldown_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ((~second_eff & (second_port_oe_n | second_port_out)) == 8'h00))
    else $error("second port low bit not strongly pulled down");

  kick_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(second_eff[0]) |-> !second_port_oe_n[0] ##1 (second_port_oe_n[0] || !second_eff[0]))
    else $error("strong pull-up not exactly one cycle");

endmodule // port_and_external_bus_pins

// File: bench/ext_mem_partner.sv
// external memory and address latch on the low port
`timescale 1ns/1ps
module ext_mem_partner (
  input wire logic aclk,
  input wire logic ale,
  input wire logic program_store_strobe_n_n,
  input wire logic read_sel,
  input wire logic [7:0] port_level,
  input wire logic [7:0] port_oe_n,
  input wire logic [7:0] addr_high,
  output logic drive_en,
  output logic [7:0] drive_val,
  output logic [7:0] addr_low_q,
  output logic [7:0] wr_q
);
  logic [7:0] hi_q;
  //==============================================================
  // address latch
  // follows the port while the strobe is high, holds after it falls
  always @(posedge aclk) begin
    if (ale) begin
      addr_low_q <= port_level;
      hi_q <= addr_high;
    end
  end
  //==============================================================
  // memory
  // answers only in the data half; a late strobe gives a wrong byte
  assign drive_en = !ale && (!program_store_strobe_n_n || read_sel);
  // data mixes both address bytes to expose a bad latch
  assign drive_val = addr_low_q ^ hi_q ^ 8'h3c;
  // a write needs every bit actively driven
  always @(posedge aclk) begin
    if (!ale && program_store_strobe_n_n && !read_sel && port_oe_n == 8'h00) begin
      wr_q <= port_level;
    end
  end
endmodule // ext_mem_partner

// File: bench/tb_port_and_external_bus_pins.sv
// self-checking bench for the pin block
`timescale 1ns/1ps
module tb_port_and_external_bus_pins;
  import pins_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic mem_req, mem_done, program_store_strobe_n, addr_latch_strobe;
  acc_kind_t mem_kind;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, addr_high_out, addr_high_oe_n, hi_q;
  logic [7:0] mux_addr_data_low_in, mux_addr_data_low_out, mux_addr_data_low_oe_n;
  logic [7:0] second_port_in, second_port_out, second_port_oe_n, second_port_weak_pullup;
  logic timer2_io_pin, timer2_drive, timer2_trigger_pin, serial1_receive, serial1_transmit;
  logic ext_irq_two_rise, ext_irq_three_fall, ext_irq_four_rise, ext_irq_five_fall;
  logic read_sel, p_drv_en, program_store_strobe_n_seen, ale_low;
  logic [7:0] p_drv, p_lat, p_wr, sp_ext, sp_ext_en;
  int err_total = 0;
  int checks_done = 0;
  int strong_cnt = 0;
  logic [3:0] irq_cnt [4];

  port_and_external_bus_pins i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req,
    .mem_kind, .mem_addr, .mem_wdata, .mem_rdata, .mem_done, .program_store_strobe_n,
    .addr_latch_strobe, .addr_high_out, .addr_high_oe_n, .mux_addr_data_low_in,
    .mux_addr_data_low_out, .mux_addr_data_low_oe_n, .second_port_in, .second_port_out,
    .second_port_oe_n, .second_port_weak_pullup, .timer2_io_pin, .timer2_drive,
    .timer2_trigger_pin, .serial1_receive, .serial1_transmit, .ext_irq_two_rise,
    .ext_irq_three_fall, .ext_irq_four_rise, .ext_irq_five_fall);

  ext_mem_partner i_mem (.aclk, .ale(addr_latch_strobe), .program_store_strobe_n_n(program_store_strobe_n),
    .read_sel, .port_level(mux_addr_data_low_in), .port_oe_n(mux_addr_data_low_oe_n),
    .addr_high(addr_high_out), .drive_en(p_drv_en), .drive_val(p_drv), .addr_low_q(p_lat),
    .wr_q(p_wr));

  //==============================================================
  // clock, pin resolution and monitors
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // low bus has pullups; second port falls back to its weak pullup
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      mux_addr_data_low_in[i] = !mux_addr_data_low_oe_n[i] ? mux_addr_data_low_out[i] :
        (p_drv_en ? p_drv[i] : 1'b1);
      second_port_in[i] = !second_port_oe_n[i] ? second_port_out[i] :
        (sp_ext_en[i] ? sp_ext[i] : second_port_weak_pullup[i]);
    end
  end
  // counted per edge, so an overlong pulse counts twice
  always @(posedge aclk) begin
    if (!second_port_oe_n[0] && second_port_out[0]) strong_cnt++;
    irq_cnt[0] += ext_irq_two_rise;
    irq_cnt[1] += ext_irq_three_fall;
    irq_cnt[2] += ext_irq_four_rise;
    irq_cnt[3] += ext_irq_five_fall;
  end

  //==============================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    err_total++;
    $display("Error at %0t: no answer to %s", $time, what);
    summarize();
  endtask
  // one register access; a write offers address and data together
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    int n;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid) break;
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
    rd_q = s_axi_rdata;
    if (n == 50) hang("register access");
    chk(wr ? s_axi_bresp : s_axi_rresp, er, "response");
  endtask
  // one external memory cycle; notes what the strobes did
  task automatic mem_op(input acc_kind_t k, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    mem_req <= 1'b1;
    mem_kind <= k;
    mem_addr <= a;
    mem_wdata <= d;
    read_sel <= (k == ACC_READ);
    program_store_strobe_n_seen = 1'b0;
    ale_low = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (!program_store_strobe_n) program_store_strobe_n_seen = 1'b1;
      if (!addr_latch_strobe) ale_low = 1'b1;
      if (!addr_high_oe_n[0]) hi_q = addr_high_out;
      if (mem_done) break;
    end
    mem_req <= 1'b0;
    read_sel <= 1'b0;
    if (n == 40) hang("memory request");
  endtask

  //==============================================================
  // scenarios
  task automatic t_reset();
    repeat (3) @(posedge aclk);
    chk(addr_latch_strobe, 1, "strobe in reset");
    chk(program_store_strobe_n, 1, "fetch strobe in reset");
    chk(mux_addr_data_low_oe_n, 8'hff, "low port released");
    chk({second_port_oe_n, second_port_weak_pullup}, 16'hffff, "second port weak");
    @(posedge aclk);
    aresetn <= 1'b1;
    $display("t_reset done");
  endtask
  task automatic t_ale();
    logic [7:0] s;
    int lows;
    repeat (4) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      s[i] = addr_latch_strobe;
    end
    chk(s[7:4], s[3:0], "strobe period");
    chk(s[3:0] inside {4'h3, 4'h6, 4'hc, 4'h9}, 1, "strobe width");
    axi(1, 8'h00, 32'h4, 2'b00);
    axi(0, 8'h00, 32'h0, 2'b00);
    chk(rd_q, 32'h4, "suppress bit");
    repeat (4) @(posedge aclk);
    lows = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      lows += !addr_latch_strobe;
    end
    chk(lows, 0, "suppressed strobe");
    mem_op(ACC_FETCH, 16'h4321, 8'h00);
    chk(ale_low, 1, "strobe in access");
    axi(1, 8'h00, 32'h0, 2'b00);
    $display("t_ale done");
  endtask
  task automatic t_mem();
    mem_op(ACC_FETCH, 16'h12c5, 8'h00);
    chk(program_store_strobe_n_seen, 1, "fetch strobe pulsed");
    chk(program_store_strobe_n, 1, "fetch strobe high");
    chk({hi_q, p_lat}, 16'h12c5, "latched address");
    chk(mem_rdata, 8'hc5 ^ 8'h12 ^ 8'h3c, "fetched byte");
    mem_op(ACC_READ, 16'h3a7e, 8'h00);
    chk(program_store_strobe_n_seen, 0, "no fetch strobe");
    chk(mem_rdata, 8'h7e ^ 8'h3a ^ 8'h3c, "read byte");
    mem_op(ACC_WRITE, 16'h0055, 8'ha5);
    chk({p_lat, p_wr}, 16'h55a5, "written byte");
    $display("t_mem done");
  endtask
  task automatic t_port();
    int c;
    axi(0, 8'h0c, 32'h0, 2'b00);
    chk(rd_q, 32'hff, "second latch");
    axi(1, 8'h0c, 32'hfe, 2'b00);
    repeat (5) @(posedge aclk);
    chk({second_port_oe_n[0], second_port_in[0]}, 2'b00, "strong pulldown");
    c = strong_cnt;
    axi(1, 8'h0c, 32'hff, 2'b00);
    repeat (3) @(posedge aclk);
    chk(strong_cnt - c, 1, "strong pull-up");
    chk({second_port_oe_n[0], second_port_weak_pullup[0]}, 2'b11, "weak pullup");
    sp_ext_en <= 8'h01;
    repeat (3) @(posedge aclk);
    axi(0, 8'h10, 32'h0, 2'b00);
    chk(rd_q, 32'hfe, "pin over pullup");
    sp_ext_en <= 8'h00;
    axi(1, 8'h04, 32'h0f, 2'b00);
    chk(mux_addr_data_low_oe_n, 8'h0f, "open-drain");
    repeat (3) @(posedge aclk);
    axi(0, 8'h08, 32'h0, 2'b00);
    chk(rd_q, 32'h0f, "low port pins");
    axi(1, 8'h04, 32'hff, 2'b00);
    axi(0, 8'h1c, 32'h0, 2'b10);
    axi(1, 8'h40, 32'h0, 2'b10);
    $display("t_port done");
  endtask
  task automatic t_alt();
    sp_ext_en <= 8'h07;
    sp_ext <= 8'h05;
    repeat (3) @(posedge aclk);
    chk({serial1_receive, timer2_trigger_pin, timer2_io_pin}, 3'b101, "alt inputs");
    sp_ext <= 8'h02;
    repeat (3) @(posedge aclk);
    chk({serial1_receive, timer2_trigger_pin, timer2_io_pin}, 3'b010, "alt inputs");
    sp_ext_en <= 8'h00;
    serial1_transmit <= 1'b0;
    timer2_drive <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(second_port_in[3:0], 4'h6, "alt outputs low");
    serial1_transmit <= 1'b1;
    timer2_drive <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(second_port_in[3:0], 4'hf, "alt outputs high");
    $display("t_alt done");
  endtask
  task automatic t_irq();
    sp_ext <= 8'hf0;
    sp_ext_en <= 8'hf0;
    repeat (3) @(posedge aclk);
    sp_ext <= 8'h00;
    repeat (3) @(posedge aclk);
    chk({irq_cnt[0], irq_cnt[1], irq_cnt[2], irq_cnt[3]}, 16'h0101, "falls");
    sp_ext <= 8'hf0;
    repeat (3) @(posedge aclk);
    chk({irq_cnt[0], irq_cnt[1], irq_cnt[2], irq_cnt[3]}, 16'h1111, "rises");
    axi(0, 8'h14, 32'h0, 2'b00);
    chk(rd_q, 32'hf, "edge flags");
    axi(1, 8'h14, 32'hf, 2'b00);
    axi(0, 8'h14, 32'h0, 2'b00);
    chk(rd_q, 32'h0, "flags cleared");
    $display("t_irq done");
  endtask

  //==============================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    s_axi_wstrb = 4'hf;
    {mem_req, read_sel, mem_addr, mem_wdata, sp_ext, sp_ext_en} = '0;
    mem_kind = ACC_FETCH;
    {timer2_drive, serial1_transmit} = 2'b11;
    irq_cnt = '{default: 4'h0};
    t_reset();
    t_ale();
    t_mem();
    t_port();
    t_alt();
    t_irq();
    summarize();
  end
endmodule // tb_port_and_external_bus_pins
